// ### rtl/led_chain_pkg.sv
// Constants, register map and types of the LED driver chain controller
package led_chain_pkg;

  // Core clock
  localparam int unsigned CLK_MHZ = 50;

  // APB register map, one aligned 32-bit word each
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_FUNC   = 8'h04;
  localparam logic [7:0]  OFS_BRIGHT = 8'h08;
  localparam logic [7:0]  OFS_STATUS = 8'h0C;
  localparam logic [7:0]  OFS_GS0    = 8'h10;
  localparam logic [7:0]  OFS_GS5    = 8'h24;
  localparam logic [7:0]  OFS_COUNT  = 8'h28;

  // Control register fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_GO_BIT   = 2;
  localparam int unsigned CTRL_CONT_BIT = 3;
  localparam int unsigned CTRL_NDEV_LSB = 16;
  localparam int unsigned NDEV_W        = 9;
  localparam logic [1:0]  MODE_INTERNAL = 2'h0;
  localparam logic [1:0]  MODE_SHIFT    = 2'h1;
  localparam logic [1:0]  MODE_LONG     = 2'h2;
  localparam logic [1:0]  MODE_RST      = 2'h0;
  localparam logic [8:0]  NDEV_RST      = 9'h001;

  // Function register fields
  localparam int unsigned FUNC_OUTTMG_BIT = 0;
  localparam int unsigned FUNC_TIMING_RESET_ON_LATCH_BIT = 1;
  localparam logic        OUTTMG_RST      = 1'b1;
  localparam logic        TIMING_RESET_ON_LATCH_RST      = 1'b0;

  // Brightness register fields
  localparam int unsigned BC_W        = 7;
  localparam int unsigned BC_RED_LSB  = 0;
  localparam int unsigned BC_GRN_LSB  = 8;
  localparam int unsigned BC_BLU_LSB  = 16;
  localparam logic [6:0]  BC_RST      = 7'h7F;

  // Status register fields
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_STATE_LSB = 1;
  localparam int unsigned ST_LIVE_BIT  = 4;

  // Packet layout, MSB first on the wire
  localparam int unsigned PKT_BITS  = 224;
  localparam int unsigned FC_W      = 5;
  localparam int unsigned GS_W      = 16;
  localparam int unsigned N_CH      = 12;
  localparam logic [5:0]  WRITE_CMD = 6'h25;
  localparam logic [7:0]  PKT_LAST  = 8'(PKT_BITS - 1);
  localparam logic [15:0] GS_RST    = 16'h0000;

  // Display period and chain arithmetic
  localparam logic [17:0] DISPLAY_CLKS = 18'h10000;
  localparam logic [17:0] PKT_CLKS     = 18'(PKT_BITS);

  // Shift clock made here by division
  localparam int unsigned SCK_PERIOD_NS  = 160;
  localparam int unsigned SCK_PERIOD_CYC = (SCK_PERIOD_NS * CLK_MHZ) / 1000;
  localparam int unsigned SCK_CNT_W      = 3;
  localparam logic [2:0]  SCK_LAST       = 3'(SCK_PERIOD_CYC - 1);
  localparam logic [2:0]  SCK_HALF       = 3'(SCK_PERIOD_CYC / 2);

  // Latch idle and PWM start gap
  localparam int unsigned LATCH_IDLE_PERIODS = 8;
  localparam int unsigned LATCH_MIN_NS       = 666;
  localparam int unsigned LATCH_MIN_CYC      = (LATCH_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned IDLE_RAW_CYC       = (LATCH_IDLE_PERIODS + 1) * SCK_PERIOD_CYC;
  localparam logic [7:0]  IDLE_LAST = 8'(((IDLE_RAW_CYC > LATCH_MIN_CYC) ? IDLE_RAW_CYC
                                          : LATCH_MIN_CYC) - 1);
  localparam int unsigned START_GAP_NS  = 1340;
  localparam int unsigned START_GAP_CYC = (START_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  GAP_LAST      = 8'(START_GAP_CYC - 1);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_LATCH,
    ST_GAP,
    ST_PWM
  } state_t;

endpackage

// ### rtl/shift_clock_gen.sv
// Divider that makes the serial shift clock and its period strobes
`timescale 1ns/1ps
`default_nettype none
module shift_clock_gen (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Run request, periods are whole while it stays high
  input  wire logic run,
  // Shift clock level and period strobes
  output logic      sck,
  output logic      period_begin,
  output logic      period_end
);
  import led_chain_pkg::*;

  logic [SCK_CNT_W-1:0] cnt_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else if (!run || cnt_r == SCK_LAST) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Left unregistered: the output flop outside adds the only lag, so data
  // launched at the begin strobe changes together with the fall
  assign sck = run && (cnt_r >= SCK_HALF);

  assign period_begin = run && (cnt_r == '0);
  assign period_end   = run && (cnt_r == SCK_LAST);

endmodule
`default_nettype wire

// ### rtl/led_chain_ctrl.sv
// APB-controlled host that loads and clocks a chain of serial LED PWM drivers
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module led_chain_ctrl (
  // Clock and reset
  input  wire logic                              CORE_CLK,
  input  wire logic                              NRST,
  // APB slave
  input  wire logic                              PSEL,
  input  wire logic                              PENABLE,
  input  wire logic                              PWRITE,
  input  wire logic [led_chain_pkg::ADDR_W-1:0]  PADDR,
  input  wire logic [led_chain_pkg::DATA_W-1:0]  PWDATA,
  output logic      [led_chain_pkg::DATA_W-1:0]  PRDATA,
  output logic                                   PREADY,
  output logic                                   PSLVERR,
  // Driver chain link
  output logic                                   SERIAL_DATA_IN,
  output logic                                   SERIAL_SHIFT_CLOCK,
  // Sequence state
  output logic                                   BUSY
);
  import led_chain_pkg::*;

  // Registers written by software
  logic [1:0]        mode_r;
  logic              cont_r;
  logic [NDEV_W-1:0] ndev_r;
  logic              outtmg_r;
  logic              timing_reset_on_latch_r;
  logic [BC_W-1:0]   bc_red_r;
  logic [BC_W-1:0]   bc_grn_r;
  logic [BC_W-1:0]   bc_blu_r;
  logic [GS_W-1:0]   gs_r [N_CH];

  // Sequencer state
  state_t            state_r;
  logic              run_r;
  logic [7:0]        bit_idx_r;
  logic [NDEV_W-1:0] dev_idx_r;
  logic [17:0]       pwm_cnt_r;
  logic [7:0]        wait_r;
  logic              live_r;
  logic [15:0]       latches_r;
  logic [15:0]       periods_r;

  // Link strobes
  logic              sck;
  logic              period_begin;
  logic              period_end;

  // Bus decode
  logic              setup;
  logic              wr_en;
  logic              start;
  logic              gs_hit;
  logic [2:0]        gs_word;
  logic [DATA_W-1:0] rdata_nxt;
  logic              err_nxt;

  // Packet and chain arithmetic
  logic [PKT_BITS-1:0] pkt;
  logic [FC_W-1:0]     fc;
  logic                ext_clk;
  logic [NDEV_W-1:0]   ndev_eff;
  logic [17:0]         load_clks;
  logic [17:0]         pwm_target;

  shift_clock_gen u_sck (
    .clk          (CORE_CLK),
    .nrst         (NRST),
    .run          (run_r),
    .sck          (sck),
    .period_begin (period_begin),
    .period_end   (period_end)
  );

  // ---------------- APB slave ----------------

  assign setup   = PSEL && !PENABLE;
  assign wr_en   = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  assign gs_hit  = (PADDR >= OFS_GS0) && (PADDR <= OFS_GS5);
  assign gs_word = 3'((PADDR - OFS_GS0) >> 2);
  // Go is only honoured from idle; a go while busy is dropped silently
  assign start   = wr_en && (PADDR == OFS_CTRL) && PWDATA[CTRL_GO_BIT] &&
                   (state_r == ST_IDLE);

  always_comb begin
    rdata_nxt = '0;
    err_nxt   = 1'b0;
    if (PADDR[1:0] != 2'b00) begin
      err_nxt = 1'b1;
    end else if (PADDR == OFS_CTRL) begin
      rdata_nxt[CTRL_MODE_LSB +: 2]      = mode_r;
      rdata_nxt[CTRL_CONT_BIT]           = cont_r;
      rdata_nxt[CTRL_NDEV_LSB +: NDEV_W] = ndev_r;
    end else if (PADDR == OFS_FUNC) begin
      rdata_nxt[FUNC_OUTTMG_BIT] = outtmg_r;
      rdata_nxt[FUNC_TIMING_RESET_ON_LATCH_BIT] = timing_reset_on_latch_r;
    end else if (PADDR == OFS_BRIGHT) begin
      rdata_nxt[BC_RED_LSB +: BC_W] = bc_red_r;
      rdata_nxt[BC_GRN_LSB +: BC_W] = bc_grn_r;
      rdata_nxt[BC_BLU_LSB +: BC_W] = bc_blu_r;
    end else if (PADDR == OFS_STATUS) begin
      rdata_nxt[ST_BUSY_BIT]       = (state_r != ST_IDLE);
      rdata_nxt[ST_STATE_LSB +: 3] = state_r;
      rdata_nxt[ST_LIVE_BIT]       = live_r;
    end else if (gs_hit) begin
      rdata_nxt = {gs_r[{gs_word, 1'b1}], gs_r[{gs_word, 1'b0}]};
    end else if (PADDR == OFS_COUNT) begin
      rdata_nxt = {periods_r, latches_r};
    end else begin
      err_nxt = 1'b1;
    end
  end

  // One wait-free access phase; answer registered in the setup cycle
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= '0;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup && err_nxt;
      PRDATA  <= (setup && !PWRITE) ? rdata_nxt : '0;
    end
  end

  // Control register; mode and chain length frozen while a sequence runs
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      mode_r <= MODE_RST;
      cont_r <= 1'b0;
      ndev_r <= NDEV_RST;
    end else if (wr_en && PADDR == OFS_CTRL) begin
      cont_r <= PWDATA[CTRL_CONT_BIT];
      if (state_r == ST_IDLE) begin
        mode_r <= PWDATA[CTRL_MODE_LSB +: 2];
        ndev_r <= PWDATA[CTRL_NDEV_LSB +: NDEV_W];
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      outtmg_r <= OUTTMG_RST;
      timing_reset_on_latch_r <= TIMING_RESET_ON_LATCH_RST;
    end else if (wr_en && PADDR == OFS_FUNC) begin
      outtmg_r <= PWDATA[FUNC_OUTTMG_BIT];
      timing_reset_on_latch_r <= PWDATA[FUNC_TIMING_RESET_ON_LATCH_BIT];
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      bc_red_r <= BC_RST;
      bc_grn_r <= BC_RST;
      bc_blu_r <= BC_RST;
    end else if (wr_en && PADDR == OFS_BRIGHT) begin
      bc_red_r <= PWDATA[BC_RED_LSB +: BC_W];
      bc_grn_r <= PWDATA[BC_GRN_LSB +: BC_W];
      bc_blu_r <= PWDATA[BC_BLU_LSB +: BC_W];
    end
  end

  // Grayscale store: two channels per word, channel k = 3*n + color
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      for (int k = 0; k < N_CH; k++) begin
        gs_r[k] <= GS_RST;
      end
    end else if (wr_en && gs_hit) begin
      gs_r[{gs_word, 1'b0}] <= PWDATA[GS_W-1:0];
      gs_r[{gs_word, 1'b1}] <= PWDATA[DATA_W-1:GS_W];
    end
  end

  // ---------------- Packet ----------------

  // Function bits forced per mode so the chain always ends up displaying
  always_comb begin
    ext_clk = (mode_r == MODE_SHIFT) || (mode_r == MODE_LONG);
    fc      = {outtmg_r,
               ext_clk,
               ext_clk ? 1'b1 : timing_reset_on_latch_r,
               !ext_clk,
               1'b0};
  end

  always_comb begin
    pkt = {WRITE_CMD, fc, bc_blu_r, bc_grn_r, bc_red_r, {(N_CH*GS_W){1'b0}}};
    for (int k = 0; k < N_CH; k++) begin
      pkt[k*GS_W +: GS_W] = gs_r[k];
    end
  end

  // Same packet goes to every device of the chain
  assign ndev_eff  = (ndev_r == '0) ? NDEV_RST : ndev_r;
  assign load_clks = 18'(PKT_CLKS * ndev_eff);

  // Long chain runs only the remainder; stopping sends a full data-low period
  always_comb begin
    if (mode_r == MODE_LONG && cont_r) begin
      pwm_target = (load_clks < DISPLAY_CLKS) ? 18'(DISPLAY_CLKS - load_clks)
                                              : 18'h00001;
    end else begin
      pwm_target = DISPLAY_CLKS;
    end
  end

  // ---------------- Sequencer ----------------

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state_r   <= ST_IDLE;
      run_r     <= 1'b0;
      bit_idx_r <= '0;
      dev_idx_r <= '0;
      pwm_cnt_r <= '0;
      wait_r    <= '0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r   <= ST_LOAD;
            run_r     <= 1'b1;
            bit_idx_r <= '0;
            dev_idx_r <= '0;
          end
        end
        ST_LOAD: begin
          if (period_end) begin
            if (bit_idx_r == PKT_LAST) begin
              bit_idx_r <= '0;
              if (dev_idx_r == ndev_eff - 1'b1) begin
                state_r <= ST_LATCH;
                run_r   <= 1'b0;
                wait_r  <= '0;
              end else begin
                dev_idx_r <= dev_idx_r + 1'b1;
              end
            end else begin
              bit_idx_r <= bit_idx_r + 1'b1;
            end
          end
        end
        ST_LATCH: begin
          if (wait_r == IDLE_LAST) begin
            wait_r  <= '0;
            state_r <= ext_clk ? ST_GAP : ST_IDLE;
          end else begin
            wait_r <= wait_r + 1'b1;
          end
        end
        ST_GAP: begin
          if (wait_r == GAP_LAST) begin
            state_r   <= ST_PWM;
            run_r     <= 1'b1;
            pwm_cnt_r <= '0;
          end else begin
            wait_r <= wait_r + 1'b1;
          end
        end
        ST_PWM: begin
          if (period_end) begin
            pwm_cnt_r <= pwm_cnt_r + 1'b1;
            if (pwm_cnt_r >= pwm_target - 1'b1) begin
              if (cont_r) begin
                state_r   <= ST_LOAD;
                bit_idx_r <= '0;
                dev_idx_r <= '0;
              end else begin
                state_r <= ST_IDLE;
                run_r   <= 1'b0;
              end
            end
          end
        end
      endcase
    end
  end

  // Data changes at the start of the low half, held over the rise
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      SERIAL_DATA_IN <= 1'b0;
    end else if (state_r == ST_LOAD) begin
      if (period_begin) begin
        SERIAL_DATA_IN <= pkt[PKT_LAST - bit_idx_r];
      end
    end else begin
      SERIAL_DATA_IN <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      SERIAL_SHIFT_CLOCK <= 1'b0;
      BUSY               <= 1'b0;
    end else begin
      SERIAL_SHIFT_CLOCK <= sck;
      BUSY               <= (state_r != ST_IDLE) || start;
    end
  end

  // Latch and display period bookkeeping for software
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      live_r    <= 1'b0;
      latches_r <= '0;
      periods_r <= '0;
    end else begin
      if (state_r == ST_LATCH && wait_r == IDLE_LAST) begin
        live_r    <= 1'b1;
        latches_r <= latches_r + 1'b1;
      end
      if (state_r == ST_PWM && period_end && pwm_cnt_r >= pwm_target - 1'b1) begin
        periods_r <= periods_r + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ### verif/led_chain_ctrl_props.sv
// Concurrent checks on the controller's APB and link ports
`timescale 1ns/1ps
`default_nettype none
module led_chain_ctrl_props
  import led_chain_pkg::*;
(
  // Clock and reset
  input wire logic                              CORE_CLK,
  input wire logic                              NRST,
  // APB
  input wire logic                              PSEL,
  input wire logic                              PENABLE,
  input wire logic                              PWRITE,
  input wire logic [led_chain_pkg::ADDR_W-1:0]  PADDR,
  input wire logic [led_chain_pkg::DATA_W-1:0]  PWDATA,
  input wire logic [led_chain_pkg::DATA_W-1:0]  PRDATA,
  input wire logic                              PREADY,
  input wire logic                              PSLVERR,
  // Link and state
  input wire logic                              SERIAL_DATA_IN,
  input wire logic                              SERIAL_SHIFT_CLOCK,
  input wire logic                              BUSY
);
  logic [7:0] low_cnt;

  // Low cycles before each rise; cleared when idle so a start counts from go
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) low_cnt <= 8'h00;
    else if (!BUSY || SERIAL_SHIFT_CLOCK) low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
  end

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  property p_ready_after_setup; PSEL && !PENABLE |=> PREADY; endproperty
  property p_ready_once; PREADY |=> !PREADY; endproperty
  property p_rdata_quiet; !PREADY |-> PRDATA == 32'h0000_0000; endproperty
  property p_err_with_ready; PSLVERR |-> PREADY; endproperty
  property p_sck_high;
    $rose(SERIAL_SHIFT_CLOCK) |-> SERIAL_SHIFT_CLOCK[*4] ##1 !SERIAL_SHIFT_CLOCK;
  endproperty
  property p_data_steady; SERIAL_SHIFT_CLOCK |-> $stable(SERIAL_DATA_IN); endproperty
  property p_sck_low; $fell(SERIAL_SHIFT_CLOCK) |-> !SERIAL_SHIFT_CLOCK[*4]; endproperty
  property p_sck_rests; !BUSY |-> !SERIAL_SHIFT_CLOCK; endproperty
  property p_go_starts;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == OFS_CTRL && PWDATA[CTRL_GO_BIT] && !BUSY
      |=> BUSY;
  endproperty
  // A long low stretch must last at least 127 cycles
  property p_latch_gap;
    $rose(SERIAL_SHIFT_CLOCK) |-> low_cnt == 8'h04 || low_cnt == 8'h05 || low_cnt >= 8'h7F;
  endproperty

  a_ready_after_setup: assert property (p_ready_after_setup) else $error("ready missing");
  a_ready_once: assert property (p_ready_once) else $error("ready held too long");
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside access");
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
  a_sck_high: assert property (p_sck_high) else $error("shift clock high phase");
  a_data_steady: assert property (p_data_steady) else $error("data moved while high");
  a_sck_low: assert property (p_sck_low) else $error("shift clock low phase");
  a_sck_rests: assert property (p_sck_rests) else $error("clock runs while idle");
  a_go_starts: assert property (p_go_starts) else $error("go did not start");
  a_latch_gap: assert property (p_latch_gap) else $error("latch gap too short");

  c_rise: cover property ($rose(SERIAL_SHIFT_CLOCK));
  c_err: cover property (PSLVERR);
  c_done: cover property ($fell(BUSY));
endmodule
`default_nettype wire

// ### verif/led_dev_model.sv
// Behavioural model of one driver at the far end of the link
`timescale 1ns/1ps
`default_nettype none
module led_dev_model (
  // Core clock samples the link
  input  wire logic         clk,
  input  wire logic         nrst,
  // Link from the controller
  input  wire logic         sdi,
  input  wire logic         sck,
  // Observed device state
  output logic [217:0]      lat,
  output int                lat_cnt,
  output int                load_rises,
  output int                rises,
  output int                hi_rises,
  output int                first_gap,
  output logic              blank,
  output logic              out_r0
);
  logic [223:0] sr;
  logic         sck_q;
  logic         rise;
  logic         lp;
  logic [15:0]  gsc;
  int           gap;
  int           idle;
  int           since_lat;
  int           thr;

  always_comb begin
    thr = 8 * gap;
    if (thr < 34) thr = 34;
    if (thr > 137000) thr = 137000;
    rise = sck && !sck_q;
    lp = !rise && idle == thr && rises > 1 && sr[223:218] == 6'h25;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sr <= '0;
      sck_q <= 1'b0;
      {gap, idle, since_lat, lat_cnt, load_rises, rises, hi_rises, first_gap} <= '0;
      lat <= '0;
    end else begin
      sck_q <= sck;
      since_lat <= since_lat + 1;
      if (rise) begin
        sr <= {sr[222:0], sdi};
        gap <= idle + 1;
        idle <= 0;
        rises <= rises + 1;
        if (sdi && lat_cnt != 0) hi_rises <= hi_rises + 1;
        if (rises == 0 && lat_cnt != 0) first_gap <= since_lat;
      end else begin
        idle <= idle + 1;
        if (lp) begin
          lat <= sr[217:0];
          lat_cnt <= lat_cnt + 1;
          load_rises <= rises;
          {rises, hi_rises, since_lat} <= '0;
        end
      end
    end
  end

  // Core clock stands in for the internal oscillator
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) gsc <= 16'h0000;
    else if (lp && sr[215]) gsc <= 16'h0000;
    else if (!blank && (lat[214] || gsc != 16'hFFFF)) begin
      if (!lat[216] || rise) gsc <= gsc + 16'h0001;
    end
  end

  assign blank = lat_cnt == 0 || lat[213];
  assign out_r0 = !blank && gsc < lat[15:0];
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the LED chain controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import led_chain_pkg::*;
  logic         CORE_CLK = 1'b0;
  logic         NRST = 1'b0;
  logic         PSEL = 1'b0;
  logic         PENABLE = 1'b0;
  logic         PWRITE = 1'b0;
  logic [7:0]   PADDR = 8'h00;
  logic [31:0]  PWDATA = 32'h0000_0000;
  logic [31:0]  PRDATA;
  logic         PREADY;
  logic         PSLVERR;
  logic         SERIAL_DATA_IN;
  logic         SERIAL_SHIFT_CLOCK;
  logic         BUSY;
  logic [217:0] lat;
  int           lat_cnt;
  int           load_rises;
  int           rises;
  int           hi_rises;
  int           first_gap;
  logic         blank;
  logic         out_r0;
  int           err_total = 0;
  int           comparisons = 0;

  always #10 CORE_CLK = ~CORE_CLK;

  led_chain_ctrl dut (.CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SERIAL_DATA_IN(SERIAL_DATA_IN),
    .SERIAL_SHIFT_CLOCK(SERIAL_SHIFT_CLOCK), .BUSY(BUSY));

  led_dev_model dev (.clk(CORE_CLK), .nrst(NRST), .sdi(SERIAL_DATA_IN),
    .sck(SERIAL_SHIFT_CLOCK), .lat(lat), .lat_cnt(lat_cnt), .load_rises(load_rises),
    .rises(rises), .hi_rises(hi_rises), .first_gap(first_gap), .blank(blank),
    .out_r0(out_r0));

  task wrap_up;
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      $display("wrong value at %0t: no bus answer", $time);
      wrap_up;
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, x);
  endtask

  // Bounded wait: 0 idle, 1 latch count, 2 clock rises since latch
  task wait_for(input int sel, input int tgt);
    int n;
    n = 0;
    while (!(sel == 0 ? BUSY === 1'b0 : sel == 1 ? lat_cnt >= tgt : rises >= tgt)) begin
      @(posedge CORE_CLK);
      n++;
      if (n > 20000) begin
        err_total++;
        $display("wrong value at %0t: wait ran out", $time);
        wrap_up;
      end
    end
  endtask

  function automatic logic [31:0] gsw(input int j);
    return {4'hC, 4'(j), 8'h01, 4'h3, 4'(j), 8'h80};
  endfunction

  task t_regs;
    logic [31:0] r;
    logic        e;
    rd_chk(OFS_CTRL, 32'(NDEV_RST) << CTRL_NDEV_LSB);
    rd_chk(OFS_FUNC, {30'h0, TIMING_RESET_ON_LATCH_RST, OUTTMG_RST});
    rd_chk(OFS_BRIGHT, {9'h0, BC_RST, 1'b0, BC_RST, 1'b0, BC_RST});
    rd_chk(OFS_GS0, {GS_RST, GS_RST});
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    rd_chk(OFS_STATUS, 32'h0000_0000);
    apb(1'b0, 8'h2C, 32'h0000_0000, r, e);
    chk(e, 1'b1);
    apb(1'b1, 8'h05, 32'h0000_0000, r, e);
    chk(e, 1'b1);
    chk(blank, 1'b1);
    chk(SERIAL_SHIFT_CLOCK, 1'b0);
    $display("register test done");
  endtask

  task t_internal;
    logic [31:0] r;
    logic        e;
    wr(OFS_FUNC, 32'h0000_0000);
    wr(OFS_BRIGHT, 32'h0033_2211);
    for (int j = 0; j < 6; j++) wr(OFS_GS0 + 8'(4 * j), gsw(j));
    wr(OFS_CTRL, 32'h0002_0004);
    // Second go while busy must be ignored
    wr(OFS_CTRL, 32'h0005_0004);
    wait_for(0, 0);
    chk(lat_cnt, 1);
    chk(load_rises, PKT_BITS * 2);
    chk(lat[217:213], 5'b00010);
    chk(lat[212:192], {7'h33, 7'h22, 7'h11});
    for (int j = 0; j < 6; j++) chk(lat[32 * j +: 32], gsw(j));
    chk(blank, 1'b0);
    apb(1'b0, OFS_COUNT, 32'h0000_0000, r, e);
    chk(r[15:0], 16'h0001);
    $display("internal oscillator test done");
  endtask

  task t_shift(input logic [1:0] mode);
    int          tgt;
    logic [31:0] cont;
    // A reset in the previous shift run put these back to their defaults
    wr(OFS_FUNC, 32'h0000_0000);
    wr(OFS_GS0, gsw(0));
    cont = (mode == MODE_LONG) ? 32'h0000_0008 : 32'h0000_0000;
    tgt = lat_cnt + 1;
    wr(OFS_CTRL, 32'h0001_0004 | 32'(mode) | cont);
    wait_for(1, tgt);
    chk(load_rises, PKT_BITS);
    chk(lat[217:213], 5'b01100);
    wait_for(2, 1);
    chk(first_gap >= START_GAP_CYC, 1'b1);
    wait_for(2, 10);
    chk(out_r0, 1'b1);
    wait_for(2, 300);
    chk(hi_rises, 0);
    chk(BUSY, 1'b1);
    rd_chk(OFS_STATUS, 32'h0000_0019);
    rd_chk(OFS_CTRL, 32'h0001_0000 | 32'(mode) | cont);
    // Reset in mid display period must stop the link at once
    NRST <= 1'b0;
    repeat (5) @(posedge CORE_CLK);
    NRST <= 1'b1;
    @(posedge CORE_CLK);
    chk(BUSY, 1'b0);
    chk(SERIAL_SHIFT_CLOCK, 1'b0);
    $display("shift clock test done, mode %0d", mode);
  endtask

  initial begin
    repeat (5) @(posedge CORE_CLK);
    NRST <= 1'b1;
    t_regs;
    t_internal;
    t_shift(MODE_SHIFT);
    t_shift(MODE_LONG);
    wrap_up;
  end

  initial begin
    repeat (100000) @(posedge CORE_CLK);
    err_total++;
    $display("wrong value at %0t: run too long", $time);
    wrap_up;
  end
endmodule

bind led_chain_ctrl led_chain_ctrl_props u_props (.CORE_CLK(CORE_CLK), .NRST(NRST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SERIAL_DATA_IN(SERIAL_DATA_IN),
  .SERIAL_SHIFT_CLOCK(SERIAL_SHIFT_CLOCK), .BUSY(BUSY));
`default_nettype wire
